// *** pkg/urx_pkg.sv ***
// Package with register map, field positions, state and carrier types of the receiver
package urx_pkg;
    // Register byte offsets
    localparam logic [4:0] URX_DATA_OFS   = 5'h00;
    localparam logic [4:0] URX_STAT_A_OFS = 5'h04;
    localparam logic [4:0] URX_CTRL_B_OFS = 5'h08;
    localparam logic [4:0] URX_CTRL_C_OFS = 5'h0c;
    localparam logic [4:0] URX_DIV_OFS    = 5'h10;
    // control_status_a fields
    localparam int URX_A_RXC_POS = 7;
    localparam int URX_A_FE_POS  = 4;
    localparam int URX_A_DOR_POS = 3;
    localparam int URX_A_PE_POS  = 2;
    localparam int URX_A_DS_POS  = 1;
    // control_status_b fields
    localparam int URX_B_IE_POS  = 7;
    localparam int URX_B_EN_POS  = 4;
    localparam int URX_B_SZ2_POS = 2;
    localparam int URX_B_RB8_POS = 1;
    // control_status_c fields
    localparam int URX_C_PEN_POS = 5;
    localparam int URX_C_ODD_POS = 4;
    localparam int URX_C_SB_POS  = 3;
    localparam int URX_C_SZL_POS = 1;
    // Reset values
    localparam logic [15:0] URX_DIV_RST  = 16'h0000;
    localparam logic [2:0]  URX_SIZE_RST = 3'h3;
    // Samples per bit, voting window and character size decoding
    localparam logic [4:0] URX_SPB_NORMAL  = 5'h10;
    localparam logic [4:0] URX_SPB_DOUBLE  = 5'h08;
    localparam logic [4:0] URX_HALF_NORMAL = 5'h08;
    localparam logic [4:0] URX_HALF_DOUBLE = 5'h04;
    localparam logic [2:0] URX_SIZE_NINE   = 3'h7;
    localparam logic [3:0] URX_MIN_BITS    = 4'h5;

    typedef enum logic [1:0] {
        URX_IDLE  = 2'b00,
        URX_START = 2'b01,
        URX_DATA  = 2'b11,
        URX_STOP  = 2'b10
    } urx_state_t;

    typedef struct packed {
        logic       fe;
        logic       overrun_flag;
        logic       pe;
        logic [8:0] data;
    } urx_frame_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [4:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } urx_avm_req_t;
endpackage : urx_pkg

// *** hw/urx_async_receiver.sv ***
// Asynchronous serial receiver with two-entry buffer and Avalon-MM register slave
//
// Functional notes
// - Receive-complete reads one while an unread frame sits in the buffer.
// - Disabling the receiver stops reception, flushes buffer, clears flag, releases pin.
// - Interrupt requested while flag set, its enable set and global enable high.
// - Error flags travel in the buffer with their frame and advance with reads.
// - Writes to control_status_a never change the three error flags.
// - Error flags never raise an interrupt.
// - Frame error is the inverse of the first stop bit, independent of stop count.
// - Overrun set when buffer full, frame waiting, and another start bit accepted.
// - Overrun cleared when a frame moves into the buffer.
// - Parity checked only when enabled; result stored with the frame.
// - Parity error reads zero when disabled; describes the next readable frame.
// - Line sampled at 16x baud, or 8x in double speed.
// - Start bit voted on samples 8-10 (4-6); majority high rejects it.
// - Bit timing restarts on every accepted start bit.
// - Bit recovery counts 16 states per bit, or 8 in double speed.
// - Each bit is the majority of its three centre samples.
// - Only the first stop bit is checked; zero sets frame error.
// - Next start edge accepted right after stop voting; one sample later at double speed.
// - After the first stop bit the frame moves toward the buffer.
// - Unused high data bits read as zero.
//
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
module urx_async_receiver (
    // Clock and reset
    input  wire logic                 sys_clk_i,
    input  wire logic                 nrst_i,
    // Avalon-MM slave
    input  wire urx_pkg::urx_avm_req_t avm_req_i,
    output logic [31:0]               avm_readdata_o,
    output logic                      avm_waitrequest_o,
    // Serial line and system
    input  wire logic                 rxd_i,
    input  wire logic                 global_irq_enable_i,
    output logic                      rx_irq_o,
    output logic                      rxd_override_o
);
    // Control registers
    logic                   receiver_enable;
    logic                   receive_done_irq_enable;
    logic                   double_speed_select;
    logic                   parity_enable_bit;
    logic                   odd_parity_select;
    logic                   stop_bit_count_select;
    logic [2:0]             character_size_field;
    logic [15:0]            baud_div;
    // Bus handshake
    logic                   ack;
    logic                   req;
    logic                   acc;
    logic                   rd_had;
    // Line sampling
    logic                   rxd_meta;
    logic                   rxd_s;
    logic [15:0]            tcnt;
    logic                   tick;
    // Recovery state
    urx_pkg::urx_state_t    state;
    logic [4:0]             scnt;
    logic [3:0]             bidx;
    logic [8:0]             rx_bits;
    logic                   pbit;
    logic                   v0;
    logic                   v1;
    logic                   maj;
    logic [4:0]             spb;
    logic [4:0]             half;
    logic                   vote_hi;
    logic [3:0]             nbits;
    logic [3:0]             last_bit;
    logic                   start_ok;
    logic                   done;
    // Shift register hold and buffer
    logic                   pend_valid;
    urx_pkg::urx_frame_t    pend;
    logic                   lost;
    urx_pkg::urx_frame_t    buf_q [2];
    logic                   rd_ptr;
    logic [1:0]             cnt;
    logic                   wr_idx;
    logic                   push;
    logic                   pop;
    logic                   rxc;
    urx_pkg::urx_frame_t    head;
    logic [31:0]            next_rdata;

    // One wait state per access keeps read data registered
    assign req               = avm_req_i.read | avm_req_i.write;
    assign avm_waitrequest_o = req & ~ack;
    assign acc               = req & ack;

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack <= 1'b0;
        end else begin
            ack <= req & ~ack;
        end
    end

    // Control register writes
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            receiver_enable         <= 1'b0;
            receive_done_irq_enable <= 1'b0;
            double_speed_select     <= 1'b0;
            parity_enable_bit       <= 1'b0;
            odd_parity_select       <= 1'b0;
            stop_bit_count_select   <= 1'b0;
            character_size_field    <= urx_pkg::URX_SIZE_RST;
            baud_div                <= urx_pkg::URX_DIV_RST;
        end else if (acc && avm_req_i.write && avm_req_i.byteenable[0]) begin
            unique case (avm_req_i.address)
                urx_pkg::URX_STAT_A_OFS: begin
                    // Error flag positions are read-only here
                    double_speed_select <= avm_req_i.writedata[urx_pkg::URX_A_DS_POS];
                end
                urx_pkg::URX_CTRL_B_OFS: begin
                    receive_done_irq_enable <= avm_req_i.writedata[urx_pkg::URX_B_IE_POS];
                    receiver_enable         <= avm_req_i.writedata[urx_pkg::URX_B_EN_POS];
                    character_size_field[2] <= avm_req_i.writedata[urx_pkg::URX_B_SZ2_POS];
                end
                urx_pkg::URX_CTRL_C_OFS: begin
                    parity_enable_bit         <= avm_req_i.writedata[urx_pkg::URX_C_PEN_POS];
                    odd_parity_select         <= avm_req_i.writedata[urx_pkg::URX_C_ODD_POS];
                    stop_bit_count_select     <= avm_req_i.writedata[urx_pkg::URX_C_SB_POS];
                    character_size_field[1:0] <=
                        avm_req_i.writedata[urx_pkg::URX_C_SZL_POS +: 2];
                end
                urx_pkg::URX_DIV_OFS: begin
                    baud_div[7:0] <= avm_req_i.writedata[7:0];
                    if (avm_req_i.byteenable[1]) begin
                        baud_div[15:8] <= avm_req_i.writedata[15:8];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Status view of the buffer head
    assign rxc  = (cnt != 2'd0);
    assign head = buf_q[rd_ptr];

    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (avm_req_i.address)
            urx_pkg::URX_DATA_OFS: begin
                // Cleared shifter keeps unused high bits at zero
                next_rdata[7:0] = rxc ? head.data[7:0] : 8'h00;
            end
            urx_pkg::URX_STAT_A_OFS: begin
                next_rdata[urx_pkg::URX_A_RXC_POS] = rxc;
                next_rdata[urx_pkg::URX_A_FE_POS]  = rxc & head.fe;
                next_rdata[urx_pkg::URX_A_DOR_POS] = rxc & head.overrun_flag;
                next_rdata[urx_pkg::URX_A_PE_POS]  = rxc & head.pe & parity_enable_bit;
                next_rdata[urx_pkg::URX_A_DS_POS]  = double_speed_select;
            end
            urx_pkg::URX_CTRL_B_OFS: begin
                next_rdata[urx_pkg::URX_B_IE_POS]  = receive_done_irq_enable;
                next_rdata[urx_pkg::URX_B_EN_POS]  = receiver_enable;
                next_rdata[urx_pkg::URX_B_SZ2_POS] = character_size_field[2];
                next_rdata[urx_pkg::URX_B_RB8_POS] = rxc & head.data[8];
            end
            urx_pkg::URX_CTRL_C_OFS: begin
                next_rdata[urx_pkg::URX_C_PEN_POS]         = parity_enable_bit;
                next_rdata[urx_pkg::URX_C_ODD_POS]         = odd_parity_select;
                next_rdata[urx_pkg::URX_C_SB_POS]          = stop_bit_count_select;
                next_rdata[urx_pkg::URX_C_SZL_POS +: 2]    = character_size_field[1:0];
            end
            urx_pkg::URX_DIV_OFS: begin
                next_rdata[15:0] = baud_div;
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    // Read data captured in the wait cycle, with the emptiness it saw
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            avm_readdata_o <= 32'h0000_0000;
            rd_had         <= 1'b0;
        end else if (req && !ack) begin
            avm_readdata_o <= next_rdata;
            rd_had         <= rxc;
        end
    end

    // Pin synchroniser
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rxd_meta <= 1'b1;
            rxd_s    <= 1'b1;
        end else begin
            rxd_meta <= rxd_i;
            rxd_s    <= rxd_meta;
        end
    end

    // Oversampling tick
    assign tick = (tcnt == baud_div);

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tcnt <= 16'h0000;
        end else if (!receiver_enable || tick) begin
            tcnt <= 16'h0000;
        end else begin
            tcnt <= tcnt + 16'h0001;
        end
    end

    // Sampling geometry
    assign spb      = double_speed_select ? urx_pkg::URX_SPB_DOUBLE
                                          : urx_pkg::URX_SPB_NORMAL;
    assign half     = double_speed_select ? urx_pkg::URX_HALF_DOUBLE
                                          : urx_pkg::URX_HALF_NORMAL;
    assign vote_hi  = (scnt == half + 5'd2);
    assign maj      = (v0 & v1) | (v0 & rxd_s) | (v1 & rxd_s);
    assign nbits    = (character_size_field == urx_pkg::URX_SIZE_NINE) ? 4'd9
                    : urx_pkg::URX_MIN_BITS + {2'b00, character_size_field[1:0]};
    assign last_bit = nbits - {3'b000, ~parity_enable_bit};
    // Tick runs on while disabled at divisor zero, so both strobes need the enable
    assign start_ok = tick && receiver_enable && state == urx_pkg::URX_START &&
                      vote_hi && !maj;
    assign done     = tick && receiver_enable && state == urx_pkg::URX_STOP &&
                      vote_hi;

    // Bit recovery machine
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state   <= urx_pkg::URX_IDLE;
            scnt    <= 5'd0;
            bidx    <= 4'd0;
            rx_bits <= 9'h000;
            pbit    <= 1'b0;
            v0      <= 1'b0;
            v1      <= 1'b0;
        end else if (!receiver_enable) begin
            state <= urx_pkg::URX_IDLE;
            scnt  <= 5'd0;
        end else if (tick) begin
            if (scnt == half) begin
                v0 <= rxd_s;
            end
            if (scnt == half + 5'd1) begin
                v1 <= rxd_s;
            end
            unique case (state)
                urx_pkg::URX_IDLE: begin
                    if (!rxd_s) begin
                        // This was sample one, so the counter names sample two next
                        state   <= urx_pkg::URX_START;
                        scnt    <= 5'd2;
                        rx_bits <= 9'h000;
                        pbit    <= 1'b0;
                    end
                end
                urx_pkg::URX_START: begin
                    scnt <= scnt + 5'd1;
                    if (vote_hi && maj) begin
                        state <= urx_pkg::URX_IDLE;
                    end else if (scnt == spb) begin
                        state <= urx_pkg::URX_DATA;
                        scnt  <= 5'd1;
                        bidx  <= 4'd0;
                    end
                end
                urx_pkg::URX_DATA: begin
                    scnt <= scnt + 5'd1;
                    if (vote_hi) begin
                        if (bidx < nbits) begin
                            rx_bits[bidx] <= maj;
                        end else begin
                            pbit <= maj;
                        end
                    end
                    if (scnt == spb) begin
                        scnt <= 5'd1;
                        bidx <= bidx + 4'd1;
                        if (bidx == last_bit) begin
                            state <= urx_pkg::URX_STOP;
                        end
                    end
                end
                urx_pkg::URX_STOP: begin
                    scnt <= scnt + 5'd1;
                    // Double speed needs one more sample before a new edge counts
                    if ((vote_hi && !double_speed_select) ||
                        (scnt == half + 5'd3)) begin
                        state <= urx_pkg::URX_IDLE;
                    end
                end
            endcase
        end
    end

    // Completed frame waits in the shift register hold
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pend_valid <= 1'b0;
            pend       <= '0;
        end else if (!receiver_enable) begin
            pend_valid <= 1'b0;
        end else if (done && (!pend_valid || push)) begin
            pend_valid <= 1'b1;
            pend.fe    <= ~maj;
            pend.overrun_flag   <= 1'b0;
            pend.pe    <= parity_enable_bit &
                          (^rx_bits ^ pbit ^ odd_parity_select);
            pend.data  <= rx_bits;
        end else if (push) begin
            pend_valid <= 1'b0;
        end
    end

    // Frames lost while buffer and hold are full
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lost <= 1'b0;
        end else if (!receiver_enable) begin
            lost <= 1'b0;
        end else if ((start_ok && pend_valid && cnt == 2'd2) ||
                     (done && pend_valid && !push)) begin
            lost <= 1'b1;
        end else if (push) begin
            lost <= 1'b0;
        end
    end

    // Two-entry receive buffer
    assign push   = pend_valid && (cnt != 2'd2);
    assign pop    = acc && avm_req_i.read &&
                    avm_req_i.address == urx_pkg::URX_DATA_OFS && rd_had;
    assign wr_idx = rd_ptr ^ cnt[0];

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt    <= 2'd0;
            rd_ptr <= 1'b0;
        end else if (!receiver_enable) begin
            cnt    <= 2'd0;
            rd_ptr <= 1'b0;
        end else begin
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            if (push && !pop) begin
                cnt <= cnt + 2'd1;
            end else if (pop && !push) begin
                cnt <= cnt - 2'd1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            buf_q[0] <= '0;
            buf_q[1] <= '0;
        end else if (push) begin
            buf_q[wr_idx]     <= pend;
            buf_q[wr_idx].overrun_flag <= lost;
        end
    end

    // Only receive-complete feeds the request line
    assign rx_irq_o       = receive_done_irq_enable & rxc & global_irq_enable_i;
    assign rxd_override_o = receiver_enable;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!nrst_i);

    a_flag_falls_empty: assert property ((pop && cnt == 2'd1 && !push) |=> !rxc)
        else $error("receive-complete still set after last frame read");
    a_disable_flushes: assert property ($fell(receiver_enable) |=>
        (cnt == 2'd0 && !pend_valid && state == urx_pkg::URX_IDLE && !rxd_override_o))
        else $error("disable did not flush receiver");
    a_irq_follows_flag: assert property (
        (receive_done_irq_enable && global_irq_enable_i && rxc)[*3] |-> rx_irq_o)
        else $error("interrupt dropped while flag set");
    a_err_write_keep: assert property ((acc && avm_req_i.write && !push && !pop &&
        avm_req_i.address == urx_pkg::URX_STAT_A_OFS) |=>
        $stable({head.fe, head.overrun_flag, head.pe}))
        else $error("software write changed error flags");
    a_irq_needs_frame: assert property (rx_irq_o |-> (cnt != 2'd0))
        else $error("interrupt without buffered frame");
    a_fe_from_stop: assert property ((done && !pend_valid) |=> pend.fe == $past(!maj))
        else $error("frame error does not match stop bit");
    a_overrun_sets: assert property ((start_ok && pend_valid && cnt == 2'd2) |=> lost)
        else $error("overrun not flagged");
    a_overrun_moves: assert property (push |=>
        (!lost && buf_q[$past(wr_idx)].overrun_flag == $past(lost)))
        else $error("overrun not transferred and cleared");
    a_pe_disabled: assert property (
        (done && !parity_enable_bit && !pend_valid) |=> !pend.pe)
        else $error("parity error set while disabled");
    a_start_reject: assert property (
        (tick && state == urx_pkg::URX_START && vote_hi && maj)
        |=> state == urx_pkg::URX_IDLE)
        else $error("noisy start bit not rejected");
    a_sample_range: assert property ((state != urx_pkg::URX_IDLE) |-> (scnt <= spb))
        else $error("sample counter beyond bit length");
    a_empty_read: assert property ((acc && avm_req_i.read && !rd_had &&
        avm_req_i.address == urx_pkg::URX_DATA_OFS && !pend_valid) |=>
        ($stable(cnt) && $stable(rd_ptr)))
        else $error("empty read changed buffer");

    c_frame_pushed: cover property (push);
    c_buffer_full:  cover property (cnt == 2'd2 && pend_valid);
    c_overrun:      cover property (start_ok && pend_valid && cnt == 2'd2);
    c_start_reject: cover property (tick && state == urx_pkg::URX_START && vote_hi && maj);
endmodule : urx_async_receiver

// *** verif/urx_line_model.sv ***
// Remote serial transmitter model driving the receive line
`timescale 1ns/1ns
module automatic urx_line_model (
    // Clock
    input  wire logic sys_clk_i,
    // Serial line, idle high as with a pull-up
    output logic      rxd_o
);
    initial rxd_o = 1'b1;

    // Caller enters just after a clock edge
    task hold(input logic v, input int n);
        rxd_o <= v;
        repeat (n) @(posedge sys_clk_i);
    endtask : hold

    // Start, data LSB first, optional parity, first stop of stop_n clocks
    task send(input logic [8:0] dat, input int nb, spb, stop_n,
              input logic pen, flip, stop_v);
        logic p;
        p = ^(dat & 9'((1 << nb) - 1)) ^ flip;
        hold(1'b0, spb);
        for (int i = 0; i < nb; i++) hold(dat[i], spb);
        if (pen) hold(p, spb);
        hold(stop_v, stop_n);
        // A low stop would look like a new start edge
        if (!stop_v) hold(1'b1, 16);
    endtask : send
endmodule : urx_line_model

// *** verif/tb_top.sv ***
// Self-checking bench for the serial receiver
`timescale 1ns/1ns
module automatic tb_top;
    localparam logic [4:0] DAT = urx_pkg::URX_DATA_OFS;
    localparam logic [4:0] STA = urx_pkg::URX_STAT_A_OFS;
    localparam logic [4:0] CTB = urx_pkg::URX_CTRL_B_OFS;
    localparam logic [4:0] CTC = urx_pkg::URX_CTRL_C_OFS;
    logic                  sys_clk_i = 1'b0;
    logic                  nrst_i = 1'b0;
    urx_pkg::urx_avm_req_t req = '0;
    logic [31:0]           rdata;
    logic                  wreq;
    logic                  rxd;
    logic                  gie = 1'b0;
    logic                  irq;
    logic                  ovr;
    logic [31:0]           d;
    int                    mismatches = 0;
    int                    check_count = 0;
    int                    cycles = 0;

    always #5 sys_clk_i = ~sys_clk_i;

    urx_async_receiver dut_u (
        .sys_clk_i           (sys_clk_i),
        .nrst_i              (nrst_i),
        .avm_req_i           (req),
        .avm_readdata_o      (rdata),
        .avm_waitrequest_o   (wreq),
        .rxd_i               (rxd),
        .global_irq_enable_i (gie),
        .rx_irq_o            (irq),
        .rxd_override_o      (ovr)
    );
    urx_line_model line_u (
        .sys_clk_i (sys_clk_i),
        .rxd_o     (rxd)
    );

    task give_verdict();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    // Whole run needs about 2300 cycles
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            mismatches++;
            give_verdict();
        end
    end

    task check(input logic [31:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== {24'h00_0000, exp}) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task bus(input logic wr, input logic [4:0] a, input logic [7:0] wd);
        @(posedge sys_clk_i);
        req.read       <= !wr;
        req.write      <= wr;
        req.address    <= a;
        req.byteenable <= 4'hf;
        req.writedata  <= {24'h00_0000, wd};
        do @(posedge sys_clk_i); while (wreq !== 1'b0);
        d = rdata;
        req.read  <= 1'b0;
        req.write <= 1'b0;
    endtask : bus

    task rdchk(input logic [4:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        check(d, e);
    endtask : rdchk

    task wait_rx();
        repeat (60) begin
            bus(1'b0, STA, 8'h00);
            if (d[7] === 1'b1) break;
        end
    endtask : wait_rx

    task t_reset();
        rdchk(STA, 8'h00);
        rdchk(CTB, 8'h00);
        rdchk(CTC, 8'h06);
        rdchk(5'h14, 8'h00);
        rdchk(DAT, 8'h00);
        rdchk(STA, 8'h00);
        $display("reset test done");
    endtask : t_reset

    task t_basic();
        bus(1'b1, CTB, 8'h90);
        // Enable lands at the acknowledging edge, so look one edge later
        @(posedge sys_clk_i);
        check({31'h0, ovr}, 8'h01);
        // Low on samples 1 to 8, so only sample 8 of the three voted: vote is high
        line_u.hold(1'b0, 8);
        line_u.hold(1'b1, 200);
        rdchk(STA, 8'h00);
        line_u.send(9'h0a5, 8, 16, 16, 1'b0, 1'b0, 1'b1);
        wait_rx();
        check({31'h0, irq}, 8'h00);
        gie <= 1'b1;
        @(posedge sys_clk_i);
        check({31'h0, irq}, 8'h01);
        rdchk(DAT, 8'ha5);
        rdchk(STA, 8'h00);
        check({31'h0, irq}, 8'h00);
        $display("basic test done");
    endtask : t_basic

    task t_errors();
        bus(1'b1, CTC, 8'h2e);
        line_u.send(9'h03c, 8, 16, 16, 1'b1, 1'b1, 1'b0);
        bus(1'b1, CTC, 8'h36);
        line_u.send(9'h0c3, 8, 16, 16, 1'b1, 1'b1, 1'b1);
        wait_rx();
        bus(1'b1, STA, 8'h00);
        rdchk(STA, 8'h94);
        check({31'h0, irq}, 8'h01);
        bus(1'b1, CTC, 8'h16);
        rdchk(STA, 8'h90);
        bus(1'b1, CTC, 8'h36);
        rdchk(DAT, 8'h3c);
        rdchk(STA, 8'h80);
        rdchk(DAT, 8'hc3);
        rdchk(STA, 8'h00);
        $display("error flag test done");
    endtask : t_errors

    task t_overrun();
        bus(1'b1, CTC, 8'h06);
        repeat (4) line_u.send(9'h0ff, 8, 16, 10, 1'b0, 1'b0, 1'b1);
        line_u.hold(1'b1, 16);
        rdchk(STA, 8'h80);
        rdchk(DAT, 8'hff);
        rdchk(STA, 8'h80);
        rdchk(DAT, 8'hff);
        rdchk(STA, 8'h88);
        rdchk(DAT, 8'hff);
        rdchk(STA, 8'h00);
        bus(1'b1, CTC, 8'h00);
        line_u.send(9'h015, 5, 16, 16, 1'b0, 1'b0, 1'b1);
        wait_rx();
        rdchk(STA, 8'h80);
        rdchk(DAT, 8'h15);
        bus(1'b1, CTC, 8'h06);
        $display("overrun test done");
    endtask : t_overrun

    task t_ninth();
        bus(1'b1, CTB, 8'h94);
        line_u.send(9'h1a5, 9, 16, 16, 1'b0, 1'b0, 1'b1);
        wait_rx();
        rdchk(CTB, 8'h96);
        rdchk(DAT, 8'ha5);
        rdchk(CTB, 8'h94);
        bus(1'b1, CTB, 8'h90);
        $display("ninth bit test done");
    endtask : t_ninth

    task t_double();
        bus(1'b1, STA, 8'h02);
        line_u.send(9'h05a, 8, 8, 8, 1'b0, 1'b0, 1'b1);
        wait_rx();
        rdchk(STA, 8'h82);
        rdchk(DAT, 8'h5a);
        bus(1'b1, STA, 8'h00);
        $display("double speed test done");
    endtask : t_double

    task t_disable();
        line_u.send(9'h011, 8, 16, 16, 1'b0, 1'b0, 1'b1);
        wait_rx();
        bus(1'b1, CTB, 8'h80);
        rdchk(STA, 8'h00);
        check({30'h0, ovr, irq}, 8'h00);
        bus(1'b1, CTB, 8'h90);
        fork
            line_u.send(9'h0f0, 8, 16, 16, 1'b0, 1'b0, 1'b1);
            bus(1'b1, CTB, 8'h80);
        join
        bus(1'b1, CTB, 8'h90);
        line_u.hold(1'b1, 40);
        rdchk(STA, 8'h00);
        $display("disable test done");
    endtask : t_disable

    initial begin
        repeat (16) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        t_reset();
        t_basic();
        t_errors();
        t_overrun();
        t_ninth();
        t_double();
        t_disable();
        give_verdict();
    end
endmodule : tb_top
